// ===== hw/nvac_pkg.sv
// Package: constants for the data EEPROM access control block
package nvac_pkg;
  // Special function register locations
  localparam logic [7:0] ADDR_REG_LOC      = 8'h40;   // Control register location in bank 1
  localparam logic [1:0] BANK_ZERO         = 2'h0;
  localparam logic [1:0] BANK_ONE          = 2'h1;
  // Control register fields
  localparam int         BIT_RD            = 0;
  localparam int         BIT_FETCH_PERMIT_BIT          = 1;
  localparam int         BIT_WR            = 2;
  localparam int         BIT_PROGRAM_PERMIT_BIT          = 3;
  localparam logic [7:0] CTRL_RESET        = 8'h00;
  localparam logic [7:0] CTRL_IMPL_MASK    = 8'h0f;
  // Array geometry
  localparam int         ADDR_W            = 6;
  localparam int         DATA_W            = 8;
  localparam int         DEPTH             = 64;
  // Timing
  localparam int         CLK_MHZ           = 50;
  localparam int         READ_CYCLES       = 4;        // Fetch duration in clocks
  localparam int         PROG_TIME_US      = 100;      // Program cycle duration in microseconds
  localparam int         PROG_CYCLES       = PROG_TIME_US * CLK_MHZ;
  // Access state machine
  typedef enum logic [1:0] {
    NVAC_IDLE  = 2'b00,
    NVAC_FETCH = 2'b01,
    NVAC_PROG  = 2'b11
  } nvac_state_t;
endpackage : nvac_pkg

// ===== hw/nvac_top.sv
// Module: data EEPROM access control, bank-mapped special function registers
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Writes to array need program permit set
// - Write trigger starts program, hardware clears after
// - Write trigger ignored unless permit already set
// - Reads of array need fetch permit set
// - Read trigger starts fetch, hardware clears after
// - Read trigger ignored unless permit already set
// - Reset clears control bits and bank selector
// - Fetched byte lands on the same clock the read trigger clears
// - Data register holds until next operation
// - Program timed by own timer; trigger clear signals
// - Cycle end sets request flag and group flag
// - Vector only when enables set, stack free
// - Service clears group flag; software clears own
// - Array is 64 bytes, 6-bit address
// - Control at 40H bank 1 via pointer only
module nvac_top #(
  parameter int PROG_COUNT = nvac_pkg::PROG_CYCLES  // Program cycle length, shortenable
) (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  // Direct special function register port (bank 0 registers)
  input  wire logic       i_addr_wr,       // Write address register
  input  wire logic       i_data_wr,       // Write data register
  input  wire logic [7:0] i_wdata,         // Write data bus
  // Bank selector and indirect pointer one
  input  wire logic       i_bank_wr,       // Write bank selector
  input  wire logic       i_ptr_wr,        // Write indirect pointer one
  input  wire logic       i_ind_wr,        // Write through indirect access one
  // Interrupt controls
  input  wire logic       i_global_irq_enable,
  input  wire logic       i_nv_irq_enable,
  input  wire logic       i_mf_irq_enable,
  input  wire logic       i_stack_full,
  input  wire logic       i_irq_service,   // Vector taken, clears group flag
  input  wire logic       i_nv_flag_clr,   // Software clears request flag
  // Register read back
  output logic [7:0]      o_nv_address_reg,
  output logic [7:0]      o_nv_data_reg,
  output logic [7:0]      o_indirect_access_one,  // Control when mapped, else zero
  output logic [1:0]      o_bank_select,
  output logic [7:0]      o_indirect_pointer_one,
  // Interrupt outputs
  output logic            o_nv_irq_flag,
  output logic            o_mf_irq_flag,
  output logic            o_irq_vector
);

  // Array storage, no reset on contents
  logic [nvac_pkg::DATA_W-1:0] mem [nvac_pkg::DEPTH];

  // Control bits and state
  logic [3:0]            ctrl;             // Permit and trigger bits
  nvac_pkg::nvac_state_t state;
  logic [15:0]           timer;            // Fetch and program timer
  logic [nvac_pkg::ADDR_W-1:0] addr;
  logic [7:0]            data;
  logic [1:0]            bank;
  logic [7:0]            ptr;
  logic                  nv_flag;
  logic                  mf_flag;
  logic                  vector;

  // Decode of the indirect window onto the control register
  wire        ctrl_mapped = (bank == nvac_pkg::BANK_ONE) && (ptr == nvac_pkg::ADDR_REG_LOC);
  wire        ctrl_wr     = i_ind_wr && ctrl_mapped;
  wire [3:0]  wr_bits     = i_wdata[3:0];  // Upper bits dropped
  // Triggers only honoured when permit was already set before this write
  wire        start_rd    = ctrl_wr && wr_bits[nvac_pkg::BIT_RD] && ctrl[nvac_pkg::BIT_FETCH_PERMIT_BIT]
                            && (state == nvac_pkg::NVAC_IDLE);
  wire        start_wr    = ctrl_wr && wr_bits[nvac_pkg::BIT_WR] && ctrl[nvac_pkg::BIT_PROGRAM_PERMIT_BIT]
                            && (state == nvac_pkg::NVAC_IDLE) && !start_rd;
  wire        fetch_done  = (state == nvac_pkg::NVAC_FETCH) && (timer == 16'(nvac_pkg::READ_CYCLES - 1));
  wire        prog_done   = (state == nvac_pkg::NVAC_PROG) && (timer == 16'(PROG_COUNT - 1));
  wire        cycle_done  = fetch_done || prog_done;
  // Write permit checked again at commit; clearing it aborts the store
  wire        commit_wr   = prog_done && ctrl[nvac_pkg::BIT_PROGRAM_PERMIT_BIT];

  // Next control: software permits, triggers held by hardware
  logic [3:0] next_ctrl;
  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_wr) begin
      next_ctrl[nvac_pkg::BIT_PROGRAM_PERMIT_BIT] = wr_bits[nvac_pkg::BIT_PROGRAM_PERMIT_BIT];
      next_ctrl[nvac_pkg::BIT_FETCH_PERMIT_BIT] = wr_bits[nvac_pkg::BIT_FETCH_PERMIT_BIT];
      // Clearing a trigger mid-cycle is not allowed; only starts set it
      next_ctrl[nvac_pkg::BIT_WR]   = ctrl[nvac_pkg::BIT_WR] | start_wr;
      next_ctrl[nvac_pkg::BIT_RD]   = ctrl[nvac_pkg::BIT_RD] | start_rd;
    end
    if (fetch_done) begin
      next_ctrl[nvac_pkg::BIT_RD] = 1'b0;
    end
    if (prog_done) begin
      next_ctrl[nvac_pkg::BIT_WR] = 1'b0;
    end
  end

  // Control, bank and pointer registers
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl <= nvac_pkg::CTRL_RESET[3:0];
      bank <= nvac_pkg::BANK_ZERO;
      ptr  <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      if (i_bank_wr) begin
        bank <= i_wdata[1:0];
      end
      if (i_ptr_wr) begin
        ptr <= i_wdata;
      end
    end
  end

  // Sequencer: the program timer is local, standing in for the array's own timer
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= nvac_pkg::NVAC_IDLE;
      timer <= 16'h0000;
    end else begin
      unique case (state)
        nvac_pkg::NVAC_IDLE: begin
          timer <= 16'h0000;
          if (start_rd) begin
            state <= nvac_pkg::NVAC_FETCH;
          end else if (start_wr) begin
            state <= nvac_pkg::NVAC_PROG;
          end
        end
        default: begin
          timer <= timer + 16'h0001;
          if (cycle_done) begin
            state <= nvac_pkg::NVAC_IDLE;
          end
        end
      endcase
    end
  end

  // Address and data registers; fetched byte loaded with the trigger clear
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr <= '0;
      data <= 8'h00;
    end else begin
      if (i_addr_wr) begin
        addr <= i_wdata[nvac_pkg::ADDR_W-1:0];
      end
      if (fetch_done && ctrl[nvac_pkg::BIT_FETCH_PERMIT_BIT]) begin
        data <= mem[addr];
      end else if (i_data_wr) begin
        data <= i_wdata;    // Otherwise held
      end
    end
  end

  // Array store on program completion
  always_ff @(posedge i_mclk) begin
    if (commit_wr) begin
      mem[addr] <= data;
    end
  end

  // Request flags: set beats clear
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      nv_flag <= 1'b0;
      mf_flag <= 1'b0;
      vector  <= 1'b0;
    end else begin
      nv_flag <= cycle_done | (nv_flag & ~i_nv_flag_clr);
      mf_flag <= cycle_done | (mf_flag & ~i_irq_service);
      vector  <= mf_flag && nv_flag && i_global_irq_enable && i_nv_irq_enable
                 && i_mf_irq_enable && !i_stack_full && !i_irq_service;
    end
  end

  // Registered read back
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_nv_address_reg       <= 8'h00;
      o_nv_data_reg          <= 8'h00;
      o_indirect_access_one  <= 8'h00;
      o_bank_select          <= 2'h0;
      o_indirect_pointer_one <= 8'h00;
      o_nv_irq_flag          <= 1'b0;
      o_mf_irq_flag          <= 1'b0;
      o_irq_vector           <= 1'b0;
    end else begin
      o_nv_address_reg       <= {2'b00, addr};
      o_nv_data_reg          <= data;
      o_indirect_access_one  <= ctrl_mapped ? ({4'h0, ctrl} & nvac_pkg::CTRL_IMPL_MASK) : 8'h00;
      o_bank_select          <= bank;
      o_indirect_pointer_one <= ptr;
      o_nv_irq_flag          <= nv_flag;
      o_mf_irq_flag          <= mf_flag;
      o_irq_vector           <= vector;
    end
  end

  // Checks
  rd_gate_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (ctrl_wr && wr_bits[0] && !ctrl[1]) |=> !ctrl[0]) else $error("read trigger set without permit");
  wr_gate_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (ctrl_wr && wr_bits[2] && !ctrl[3]) |=> !ctrl[2]) else $error("write trigger set without permit");
  fetch_len_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    start_rd |=> ctrl[0] [*4] ##1 !ctrl[0]) else $error("fetch length wrong");
  flag_set_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    cycle_done |=> nv_flag && mf_flag) else $error("flags not set at cycle end");
  trig_clr_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    prog_done |=> !ctrl[2]) else $error("write trigger not cleared");
  data_hold_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (!fetch_done && !i_data_wr) |=> $stable(data)) else $error("data register changed");
  vec_gate_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (i_stack_full || !i_global_irq_enable) |=> !vector) else $error("vector while blocked");
  hi_zero_a: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_indirect_access_one[7:4] == 4'h0) else $error("upper control bits nonzero");
  rd_cov: cover property (@(posedge i_mclk) disable iff (!i_nrst) fetch_done);
  wr_cov: cover property (@(posedge i_mclk) disable iff (!i_nrst) commit_wr);
  vec_cov: cover property (@(posedge i_mclk) disable iff (!i_nrst) vector);

endmodule : nvac_top // nvac_top
`default_nettype wire

// ===== dv/nvac_array_model.sv
// Expected image of the 64-byte non-volatile array behind the control block
`timescale 1ns/10ps
`default_nettype none
module nvac_array_model;
  // Unwritten bytes stay unknown, so a fetch of them passes the !== compare against the equally unknown array byte
  logic [7:0] image [nvac_pkg::DEPTH];  // One byte per location
  // Record a committed program cycle
  task automatic put(input logic [5:0] a, input logic [7:0] d);
    image[a] = d;
  endtask
endmodule // nvac_array_model
`default_nettype wire

// ===== dv/nvac_top_tb.sv
// Self-checking bench for the data EEPROM access control block
`timescale 1ns/10ps
`default_nettype none
module nvac_top_tb;
  localparam int PROG = 8;  // Shortened program cycle keeps the run brief
  logic       i_mclk, i_nrst, i_addr_wr, i_data_wr, i_bank_wr, i_ptr_wr, i_ind_wr;
  logic [7:0] i_wdata;
  logic       i_global_irq_enable, i_nv_irq_enable, i_mf_irq_enable;
  logic       i_stack_full, i_irq_service, i_nv_flag_clr;
  wire  [7:0] o_nv_address_reg, o_nv_data_reg, o_indirect_access_one, o_indirect_pointer_one;
  wire  [1:0] o_bank_select;
  wire        o_nv_irq_flag, o_mf_irq_flag, o_irq_vector;
  int         errors, comparisons;
  nvac_array_model model ();
  nvac_top #(.PROG_COUNT(PROG)) uut (.i_mclk, .i_nrst, .i_addr_wr, .i_data_wr, .i_wdata, .i_bank_wr,
    .i_ptr_wr, .i_ind_wr, .i_global_irq_enable, .i_nv_irq_enable, .i_mf_irq_enable, .i_stack_full,
    .i_irq_service, .i_nv_flag_clr, .o_nv_address_reg, .o_nv_data_reg, .o_indirect_access_one,
    .o_bank_select, .o_indirect_pointer_one, .o_nv_irq_flag, .o_mf_irq_flag, .o_irq_vector);
  // Clock, 20 ns period
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // Compare and count
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // One strobe cycle: 0 address, 1 data, 2 bank, 3 pointer, 4 indirect
  task automatic sfr(input int sel, input logic [7:0] v);
    @(posedge i_mclk);
    #1;
    i_wdata = v;
    {i_ind_wr, i_ptr_wr, i_bank_wr, i_data_wr, i_addr_wr} = 5'h01 << sel;
    idle(1);
    {i_ind_wr, i_ptr_wr, i_bank_wr, i_data_wr, i_addr_wr} = 5'h00;
  endtask
  // Bounded poll until a trigger bit drops; no other access meanwhile
  task automatic wait_clr(input int b, input int lim);
    int n;
    n = 0;
    while (o_indirect_access_one[b] !== 1'b0 && n < lim) begin
      idle(1);
      n++;
    end
    if (n >= lim) chk("trigger clear", 8'h00, 8'h01);
  endtask
  // Service the group flag, then drop the request flag by hand
  task automatic clr_flags;
    @(posedge i_mclk);
    #1 i_irq_service = 1'b1;
    idle(1);
    i_irq_service = 1'b0;
    idle(2);
    chk("flags served", 8'h02, {6'h00, o_nv_irq_flag, o_mf_irq_flag});
    i_nv_flag_clr = 1'b1;
    idle(1);
    i_nv_flag_clr = 1'b0;
    idle(2);
    chk("flags cleared", 8'h00, {6'h00, o_nv_irq_flag, o_mf_irq_flag});
  endtask
  // Program one byte, interrupts masked around the permit/trigger pair
  task automatic prog(input logic [5:0] a, input logic [7:0] d, input logic full);
    i_stack_full = full;
    sfr(0, {2'h0, a});
    sfr(1, d);
    i_global_irq_enable = 1'b0;
    sfr(4, 8'h08);
    sfr(4, 8'h0c);
    i_global_irq_enable = 1'b1;
    idle(1);
    chk("ctrl program", 8'h0c, o_indirect_access_one);
    wait_clr(2, PROG + 3);
    model.put(a, d);
    chk("ctrl programmed", 8'h08, o_indirect_access_one);
    idle(3);
    chk("flags", 8'h03, {6'h00, o_nv_irq_flag, o_mf_irq_flag});
    chk("vector", {7'h00, ~full}, {7'h00, o_irq_vector});
    clr_flags();
  endtask
  // Fetch one byte; data register preloaded with the complement
  task automatic fetch(input logic [5:0] a);
    sfr(4, 8'h02);
    sfr(0, {2'h0, a});
    sfr(1, ~model.image[a]);
    sfr(4, 8'h03);
    idle(1);
    chk("ctrl fetch", 8'h03, o_indirect_access_one);
    chk("address", {2'h0, a}, o_nv_address_reg);
    wait_clr(0, nvac_pkg::READ_CYCLES + 3);
    chk("fetched", model.image[a], o_nv_data_reg);
    chk("ctrl fetched", 8'h02, o_indirect_access_one);
    idle(3);
    chk("held", model.image[a], o_nv_data_reg);
    chk("flags", 8'h03, {6'h00, o_nv_irq_flag, o_mf_irq_flag});
    clr_flags();
  endtask
  // Verdict, the single end of the run
  task automatic end_of_test;
    if (errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog, well beyond the few hundred cycles needed
  initial begin
    #(20 * 4000);
    errors++;
    end_of_test();
  end
  // Main sequence
  initial begin
    {i_ind_wr, i_ptr_wr, i_bank_wr, i_data_wr, i_addr_wr} = 5'h00;
    i_wdata = 8'h00;
    {i_global_irq_enable, i_nv_irq_enable, i_mf_irq_enable} = 3'h7;
    {i_stack_full, i_irq_service, i_nv_flag_clr} = 3'h0;
    i_nrst = 1'b0;
    repeat (10) @(posedge i_mclk);
    #1 i_nrst = 1'b1;
    chk("ctrl reset", 8'h00, o_indirect_access_one);
    chk("bank reset", 8'h00, {6'h00, o_bank_select});
    // Bank 0 still selected, so the indirect write must miss
    sfr(3, nvac_pkg::ADDR_REG_LOC);
    sfr(4, 8'h0a);
    idle(2);
    chk("pointer", nvac_pkg::ADDR_REG_LOC, o_indirect_pointer_one);
    chk("ctrl unmapped", 8'h00, o_indirect_access_one);
    sfr(2, {6'h00, nvac_pkg::BANK_ONE});
    sfr(4, 8'hf0);
    idle(2);
    chk("ctrl upper", 8'h00, o_indirect_access_one);
    chk("bank", 8'h01, {6'h00, o_bank_select});
    sfr(4, 8'h04);
    idle(2);
    chk("write refused", 8'h00, o_indirect_access_one);
    sfr(4, 8'h01);
    idle(2);
    chk("read refused", 8'h00, o_indirect_access_one);
    prog(6'h3f, 8'ha5, 1'b0);
    prog(6'h00, 8'h5a, 1'b1);
    fetch(6'h3f);
    fetch(6'h00);
    // Trigger with permit dropped must leave the array alone
    sfr(0, 8'h00);
    sfr(1, 8'hff);
    sfr(4, 8'h00);
    sfr(4, 8'h04);
    idle(2);
    chk("write inhibited", 8'h00, o_indirect_access_one);
    // Permit dropped mid-cycle: trigger still clears, store is skipped
    sfr(4, 8'h08);
    sfr(4, 8'h0c);
    sfr(4, 8'h04);
    wait_clr(2, PROG + 3);
    chk("ctrl aborted", 8'h00, o_indirect_access_one);
    // Read permit dropped mid-fetch: data register keeps its byte
    sfr(4, 8'h02);
    sfr(1, 8'h33);
    sfr(4, 8'h03);
    sfr(4, 8'h01);
    wait_clr(0, nvac_pkg::READ_CYCLES + 3);
    chk("fetch inhibited", 8'h33, o_nv_data_reg);
    fetch(6'h00);
    end_of_test();
  end
endmodule // nvac_top_tb
`default_nettype wire
